// ==== shared/gpio_clk_pkg.sv ====
// constants for the multi-function pin and clock generation block
// assumes one 100 MHz system clock; audio clocks arrive as edge enables
package gpio_clk_pkg;
  // register word offsets on the control port
  localparam logic [6:0] ADDR_POWER_MGMT_ONE = 7'h01;
  localparam logic [6:0] ADDR_CLOCK_CONTROL  = 7'h06;
  localparam logic [6:0] ADDR_SAMPLE_SLOW    = 7'h07;
  localparam logic [6:0] ADDR_PIN_CONTROL    = 7'h08;
  localparam logic [6:0] ADDR_PLL_INTEGER    = 7'h24;
  localparam logic [6:0] ADDR_PLL_FRAC_HIGH  = 7'h25;
  localparam logic [6:0] ADDR_PLL_FRAC_MID   = 7'h26;
  localparam logic [6:0] ADDR_PLL_FRAC_LOW   = 7'h27;
  // values after reset
  localparam logic [8:0] RST_POWER_MGMT_ONE = 9'h000;
  localparam logic [8:0] RST_CLOCK_CONTROL  = 9'h140;
  localparam logic [8:0] RST_SAMPLE_SLOW    = 9'h000;
  localparam logic [8:0] RST_PIN_CONTROL    = 9'h000;
  localparam logic [8:0] RST_PLL_INTEGER    = 9'h008;
  localparam logic [8:0] RST_PLL_FRAC_HIGH  = 9'h00c;
  localparam logic [8:0] RST_PLL_FRAC_MID   = 9'h093;
  localparam logic [8:0] RST_PLL_FRAC_LOW   = 9'h0e9;
  // field positions
  localparam int POS_PLL_ENABLE      = 5;
  localparam int POS_CLOCK_MODE      = 8;
  localparam int POS_PRESCALE_LSB    = 5;
  localparam int POS_BCLK_DIV_LSB    = 2;
  localparam int POS_CLOCK_PINS_OUT  = 0;
  localparam int POS_SAMPLE_RATE_LSB = 1;
  localparam int POS_SLOW_ENABLE     = 0;
  localparam int POS_GPIO_SEL_LSB    = 0;
  localparam int POS_GPIO_POLARITY   = 3;
  localparam int POS_GPIO_CLKDIV_LSB = 4;
  localparam int POS_PLL_PRESCALE    = 4;
  // pin function codes
  localparam logic [2:0] FN_CHIP_SELECT = 3'h0;
  localparam logic [2:0] FN_JACK_DETECT = 3'h1;
  localparam logic [2:0] FN_TEMP_OK     = 3'h2;
  localparam logic [2:0] FN_MUTE_ACTIVE = 3'h3;
  localparam logic [2:0] FN_PLL_CLOCK   = 3'h4;
  localparam logic [2:0] FN_PLL_LOCK    = 3'h5;
  localparam logic [2:0] FN_DRIVE_HIGH  = 3'h6;
  localparam logic [2:0] FN_DRIVE_LOW   = 3'h7;
  // slow timer: period in ms, counted in master clock periods
  localparam int SLOW_PERIOD_MS = 128;
  localparam int RATE_UNIT_HZ   = 4000;
  localparam int INTERNAL_MASTER_CLOCK_PER_FS   = 256;
  localparam int SLOW_UNIT_DFLT =
    SLOW_PERIOD_MS * RATE_UNIT_HZ * INTERNAL_MASTER_CLOCK_PER_FS / 1000;
  localparam int SLOW_CNT_W     = 21;
endpackage

// ==== hdl/gpio_and_clock_generation.sv ====
// multi-function pin logic, slow timer and audio clock generation
// assumes register writes from the control port decoder, audio source
// clock edges as one-cycle enables and all inputs synchronous to i_clk
`timescale 1ns/1ps
module gpio_and_clock_generation
  import gpio_clk_pkg::*;
#(
  parameter int SLOW_UNIT = SLOW_UNIT_DFLT
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // register port from the control interface
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic [8:0] i_reg_wdata,
  output logic      [8:0] o_reg_rdata,
  // control interface mode and settings held elsewhere
  input  wire logic       i_two_wire_mode,
  input  wire logic       i_speaker_pos_enable,
  input  wire logic       i_speaker_neg_enable,
  input  wire logic       i_mono_out_enable,
  input  wire logic       i_thermal_sense_enable,
  input  wire logic       i_fs_pulse_format,
  // status from analog and pll
  input  wire logic       i_over_temp,
  input  wire logic       i_analog_mute_active,
  input  wire logic       i_pll_locked,
  // source clock edges, one pulse per edge
  input  wire logic       i_mclk_edge,
  input  wire logic       i_pll_edge,
  // multi-function pin
  input  wire logic       i_chip_select_pin,
  output logic            o_chip_select_pin,
  output logic            o_chip_select_pin_oe,
  output logic            o_spi_select_n,
  // output routing
  output logic            o_speaker_pos_enable,
  output logic            o_speaker_neg_enable,
  output logic            o_mono_out_enable,
  // timing
  output logic            o_slow_tick,
  output logic            o_internal_master_clock_tick,
  // audio clock pins
  output logic            o_frame_sync,
  output logic            o_frame_sync_oe,
  output logic            o_bit_clock,
  output logic            o_bit_clock_oe,
  // pll settings
  output logic      [3:0] o_pll_integer_part,
  output logic     [23:0] o_pll_fraction_part,
  output logic            o_pll_input_prescale
);

  // the fastest rate needs twelve units inside the counter
  if (SLOW_UNIT < 1 || SLOW_UNIT * 12 >= (1 << SLOW_CNT_W)) begin
    $error("SLOW_UNIT out of range");
  end

  // register group
  logic [8:0] pm1_r, clk_ctl_r, sr_r, pin_r, pll_int_r;
  logic [8:0] frac_h_r, frac_m_r, frac_l_r, rdata_r;
  logic [8:0] pm1_nxt, clk_ctl_nxt, sr_nxt, pin_nxt, pll_int_nxt;
  logic [8:0] frac_h_nxt, frac_m_nxt, frac_l_nxt, rdata_nxt;

  always_comb begin
    pm1_nxt     = pm1_r;
    clk_ctl_nxt = clk_ctl_r;
    sr_nxt      = sr_r;
    pin_nxt     = pin_r;
    pll_int_nxt = pll_int_r;
    frac_h_nxt  = frac_h_r;
    frac_m_nxt  = frac_m_r;
    frac_l_nxt  = frac_l_r;
    rdata_nxt   = rdata_r;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_POWER_MGMT_ONE: pm1_nxt = i_reg_wdata;
        ADDR_CLOCK_CONTROL:  clk_ctl_nxt = i_reg_wdata & 9'h1fd;
        ADDR_SAMPLE_SLOW:    sr_nxt = i_reg_wdata & 9'h00f;
        ADDR_PIN_CONTROL:    pin_nxt = i_reg_wdata & 9'h03f;
        ADDR_PLL_INTEGER:    pll_int_nxt = i_reg_wdata & 9'h01f;
        ADDR_PLL_FRAC_HIGH:  frac_h_nxt = i_reg_wdata & 9'h03f;
        ADDR_PLL_FRAC_MID:   frac_m_nxt = i_reg_wdata;
        ADDR_PLL_FRAC_LOW:   frac_l_nxt = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_POWER_MGMT_ONE: rdata_nxt = pm1_r;
        ADDR_CLOCK_CONTROL:  rdata_nxt = clk_ctl_r;
        ADDR_SAMPLE_SLOW:    rdata_nxt = sr_r;
        ADDR_PIN_CONTROL:    rdata_nxt = pin_r;
        ADDR_PLL_INTEGER:    rdata_nxt = pll_int_r;
        ADDR_PLL_FRAC_HIGH:  rdata_nxt = frac_h_r;
        ADDR_PLL_FRAC_MID:   rdata_nxt = frac_m_r;
        ADDR_PLL_FRAC_LOW:   rdata_nxt = frac_l_r;
        default:             rdata_nxt = 9'h000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pm1_r     <= RST_POWER_MGMT_ONE;
      clk_ctl_r <= RST_CLOCK_CONTROL;
      sr_r      <= RST_SAMPLE_SLOW;
      pin_r     <= RST_PIN_CONTROL;
      pll_int_r <= RST_PLL_INTEGER;
      frac_h_r  <= RST_PLL_FRAC_HIGH;
      frac_m_r  <= RST_PLL_FRAC_MID;
      frac_l_r  <= RST_PLL_FRAC_LOW;
      rdata_r   <= 9'h000;
    end else begin
      pm1_r     <= pm1_nxt;
      clk_ctl_r <= clk_ctl_nxt;
      sr_r      <= sr_nxt;
      pin_r     <= pin_nxt;
      pll_int_r <= pll_int_nxt;
      frac_h_r  <= frac_h_nxt;
      frac_m_r  <= frac_m_nxt;
      frac_l_r  <= frac_l_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // field views
  logic [2:0] fn_sel, pre_sel, bclk_sel, rate_sel;
  logic [1:0] pin_div;
  logic       polarity, slow_en, master, pll_src, pll_edge;
  assign fn_sel   = pin_r[POS_GPIO_SEL_LSB +: 3];
  assign polarity = pin_r[POS_GPIO_POLARITY];
  assign pin_div  = pin_r[POS_GPIO_CLKDIV_LSB +: 2];
  assign slow_en  = sr_r[POS_SLOW_ENABLE];
  assign rate_sel = sr_r[POS_SAMPLE_RATE_LSB +: 3];
  assign pll_src  = clk_ctl_r[POS_CLOCK_MODE];
  assign pre_sel  = clk_ctl_r[POS_PRESCALE_LSB +: 3];
  assign bclk_sel = clk_ctl_r[POS_BCLK_DIV_LSB +: 3];
  assign master   = clk_ctl_r[POS_CLOCK_PINS_OUT];
  // a powered-down pll gives no edges
  assign pll_edge = i_pll_edge & pm1_r[POS_PLL_ENABLE];

  // clocking group
  logic [3:0]            pre_cnt_r, pre_cnt_nxt;
  logic [7:0]            frame_r, frame_nxt;
  logic [SLOW_CNT_W-1:0] slow_cnt_r, slow_cnt_nxt, slow_limit;
  logic                  internal_master_clock_r, internal_master_clock_nxt, slow_tick_r, slow_tick_nxt;
  logic                  fs_r, fs_nxt, bclk_r, bclk_nxt, src_edge;
  logic [3:0]            rate_factor;

  always_comb begin
    unique case (rate_sel)
      3'h0:    rate_factor = 4'hc;
      3'h1:    rate_factor = 4'h8;
      3'h2:    rate_factor = 4'h6;
      3'h3:    rate_factor = 4'h4;
      3'h4:    rate_factor = 4'h3;
      default: rate_factor = 4'h2;
    endcase
  end
  // limit in master clock periods, so a wrong rate scales the period
  assign slow_limit = SLOW_CNT_W'(SLOW_UNIT * int'(rate_factor));

  assign src_edge = pll_src ? pll_edge : i_mclk_edge;

  always_comb begin
    pre_cnt_nxt   = pre_cnt_r;
    internal_master_clock_nxt     = 1'b0;
    frame_nxt     = frame_r;
    slow_cnt_nxt  = slow_cnt_r;
    slow_tick_nxt = 1'b0;
    fs_nxt        = 1'b0;
    bclk_nxt      = 1'b0;
    if (src_edge) begin
      // two edges per source period, factor is select plus one
      if (pre_cnt_r >= {pre_sel, 1'b1}) begin
        pre_cnt_nxt = 4'h0;
        internal_master_clock_nxt   = 1'b1;
      end else begin
        pre_cnt_nxt = pre_cnt_r + 4'h1;
      end
    end
    // a new ratio or source restarts the count so no period overshoots
    if (clk_ctl_nxt[POS_CLOCK_MODE:POS_PRESCALE_LSB] !=
        clk_ctl_r[POS_CLOCK_MODE:POS_PRESCALE_LSB]) begin
      pre_cnt_nxt = 4'h0;
    end
    if (internal_master_clock_r) begin
      frame_nxt = frame_r + 8'h01;
    end
    // a new rate restarts the count so no period overshoots
    if (!slow_en || sr_nxt[POS_SAMPLE_RATE_LSB +: 3] != rate_sel) begin
      slow_cnt_nxt = '0;
    end else if (internal_master_clock_r) begin
      if (slow_cnt_r >= slow_limit - SLOW_CNT_W'(1)) begin
        slow_cnt_nxt  = '0;
        slow_tick_nxt = 1'b1;
      end else begin
        slow_cnt_nxt = slow_cnt_r + SLOW_CNT_W'(1);
      end
    end
    if (master) begin
      bclk_nxt = ~frame_r[bclk_sel];
      if (i_fs_pulse_format) begin
        fs_nxt = (frame_r >> bclk_sel) < 8'h02;
      end else begin
        fs_nxt = ~frame_r[7];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_r   <= 4'h0;
      internal_master_clock_r     <= 1'b0;
      frame_r     <= 8'h00;
      slow_cnt_r  <= '0;
      slow_tick_r <= 1'b0;
      fs_r        <= 1'b0;
      bclk_r      <= 1'b0;
    end else begin
      pre_cnt_r   <= pre_cnt_nxt;
      internal_master_clock_r     <= internal_master_clock_nxt;
      frame_r     <= frame_nxt;
      slow_cnt_r  <= slow_cnt_nxt;
      slow_tick_r <= slow_tick_nxt;
      fs_r        <= fs_nxt;
      bclk_r      <= bclk_nxt;
    end
  end

  // pin group
  logic [1:0] pdiv_cnt_r, pdiv_cnt_nxt;
  logic       pclk_r, pclk_nxt, jack_r, jack_nxt, stable_r, stable_nxt;
  logic       last_r, last_nxt, pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
  logic       cs_r, cs_nxt, spk_p_r, spk_n_r, mono_r;
  logic       spk_p_nxt, spk_n_nxt, mono_nxt, jack_mode, sample, level;

  assign jack_mode = i_two_wire_mode && fn_sel == FN_JACK_DETECT;
  assign sample    = i_chip_select_pin ^ polarity;

  always_comb begin
    pdiv_cnt_nxt = pdiv_cnt_r;
    pclk_nxt     = pclk_r;
    jack_nxt     = jack_r;
    stable_nxt   = stable_r;
    last_nxt     = sample;
    if (pll_edge) begin
      if (pdiv_cnt_r >= pin_div) begin
        pdiv_cnt_nxt = 2'h0;
        pclk_nxt     = ~pclk_r;
      end else begin
        pdiv_cnt_nxt = pdiv_cnt_r + 2'h1;
      end
    end
    // a change anywhere in the interval voids it
    if (!jack_mode || !slow_en) begin
      stable_nxt = 1'b0;
    end else if (slow_tick_r) begin
      if (stable_r && sample == last_r) begin
        jack_nxt = sample;
      end
      stable_nxt = 1'b1;
    end else if (sample != last_r) begin
      stable_nxt = 1'b0;
    end
    unique case (fn_sel)
      FN_TEMP_OK:    level = ~(i_thermal_sense_enable & i_over_temp);
      FN_MUTE_ACTIVE: level = i_analog_mute_active;
      FN_PLL_CLOCK:  level = pclk_r;
      FN_PLL_LOCK:   level = ~i_pll_locked;
      FN_DRIVE_HIGH: level = 1'b1;
      FN_DRIVE_LOW:  level = 1'b0;
      default:       level = 1'b0;
    endcase
    pin_out_nxt = level ^ polarity;
    // general functions only in 2-wire mode; 0 and 1 are inputs
    pin_oe_nxt = i_two_wire_mode && fn_sel >= FN_TEMP_OK;
    cs_nxt = (i_two_wire_mode && fn_sel != FN_CHIP_SELECT)
             ? 1'b1 : i_chip_select_pin;
    spk_p_nxt = i_speaker_pos_enable;
    spk_n_nxt = i_speaker_neg_enable;
    mono_nxt  = i_mono_out_enable;
    if (jack_mode) begin
      spk_p_nxt = i_speaker_pos_enable & ~jack_r;
      spk_n_nxt = i_speaker_neg_enable & ~jack_r;
      mono_nxt  = i_mono_out_enable & jack_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pdiv_cnt_r <= 2'h0;
      pclk_r     <= 1'b0;
      jack_r     <= 1'b0;
      stable_r   <= 1'b0;
      last_r     <= 1'b0;
      pin_out_r  <= 1'b0;
      pin_oe_r   <= 1'b0;
      cs_r       <= 1'b1;
      spk_p_r    <= 1'b0;
      spk_n_r    <= 1'b0;
      mono_r     <= 1'b0;
    end else begin
      pdiv_cnt_r <= pdiv_cnt_nxt;
      pclk_r     <= pclk_nxt;
      jack_r     <= jack_nxt;
      stable_r   <= stable_nxt;
      last_r     <= last_nxt;
      pin_out_r  <= pin_out_nxt;
      pin_oe_r   <= pin_oe_nxt;
      cs_r       <= cs_nxt;
      spk_p_r    <= spk_p_nxt;
      spk_n_r    <= spk_n_nxt;
      mono_r     <= mono_nxt;
    end
  end

  assign o_reg_rdata          = rdata_r;
  assign o_chip_select_pin    = pin_out_r;
  assign o_chip_select_pin_oe = pin_oe_r;
  assign o_spi_select_n       = cs_r;
  assign o_speaker_pos_enable = spk_p_r;
  assign o_speaker_neg_enable = spk_n_r;
  assign o_mono_out_enable    = mono_r;
  assign o_slow_tick          = slow_tick_r;
  assign o_internal_master_clock_tick         = internal_master_clock_r;
  assign o_frame_sync         = fs_r;
  assign o_bit_clock          = bclk_r;
  // slave mode leaves both audio clock pins to the far side
  assign o_frame_sync_oe      = clk_ctl_r[POS_CLOCK_PINS_OUT];
  assign o_bit_clock_oe       = clk_ctl_r[POS_CLOCK_PINS_OUT];
  assign o_pll_integer_part   = pll_int_r[3:0];
  assign o_pll_fraction_part  = {frac_h_r[5:0], frac_m_r, frac_l_r};
  assign o_pll_input_prescale = pll_int_r[POS_PLL_PRESCALE];

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence jack_stable_tick;
    slow_tick_r && stable_r && jack_mode && slow_en;
  endsequence

  a_cs_passthrough: assert property (
    (!i_two_wire_mode) |=> o_spi_select_n == $past(i_chip_select_pin)
  ) else $error("chip select not passed through");
  a_spi_no_drive: assert property (
    (!i_two_wire_mode) |=> !o_chip_select_pin_oe
  ) else $error("pin driven in spi mode");
  a_lock_level: assert property (
    (i_two_wire_mode && fn_sel == FN_PLL_LOCK) |=>
      o_chip_select_pin == ($past(~i_pll_locked) ^ $past(polarity))
  ) else $error("lock level wrong");
  a_fixed_high: assert property (
    (fn_sel == FN_DRIVE_HIGH && !polarity)[*2] |-> o_chip_select_pin
  ) else $error("fixed high not driven");
  a_thermal_direct: assert property (
    (fn_sel == FN_TEMP_OK && i_thermal_sense_enable && i_over_temp) |=>
      o_chip_select_pin == $past(polarity)
  ) else $error("thermal alert missing");
  a_jack_routes: assert property (
    (jack_mode && jack_r) |=> !o_speaker_pos_enable && !o_speaker_neg_enable
  ) else $error("speaker on with jack in");
  a_jack_update: assert property (
    $changed(jack_r) |-> $past(slow_tick_r) && $past(stable_r)
  ) else $error("jack state changed off a tick");
  a_jack_settle: assert property (
    jack_stable_tick ##0 (sample == last_r) |=> jack_r == $past(sample)
  ) else $error("stable jack level not taken");
  a_slow_off: assert property (
    !slow_en |=> !o_slow_tick
  ) else $error("slow tick while disabled");
  a_slow_period: assert property (
    slow_tick_nxt |-> slow_cnt_r == slow_limit - SLOW_CNT_W'(1)
  ) else $error("slow tick period wrong");
  a_prescale: assert property (
    internal_master_clock_nxt |-> src_edge && pre_cnt_r == {pre_sel, 1'b1}
  ) else $error("prescale ratio wrong");
  a_fs_rate: assert property (
    (master && !i_fs_pulse_format && internal_master_clock_r && frame_r == 8'hff) |=>
      ##1 o_frame_sync
  ) else $error("frame sync not at frame start");

endmodule

// ==== dv/clock_source_model.sv ====
// far-side model: master clock pin and pll output edge trains
// assumes edges are one-cycle pulses synchronous to i_clk
`timescale 1ns/1ps
module clock_source_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // pacing: slow stretches the master clock pin edges
  input  wire logic i_slow,
  // source clock edges
  output logic      o_mclk_edge,
  output logic      o_pll_edge
);
  logic [3:0] ref_cnt_r;
  logic       mclk_nxt;

  assign mclk_nxt = i_slow ? (ref_cnt_r[1:0] == 2'h0) : !ref_cnt_r[0];

  // one counter feeds both trains so they never drift apart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt_r   <= 4'h0;
      o_mclk_edge <= 1'b0;
      o_pll_edge  <= 1'b0;
    end else begin
      ref_cnt_r   <= (ref_cnt_r == 4'hb) ? 4'h0 : ref_cnt_r + 4'h1;
      o_mclk_edge <= mclk_nxt;
      o_pll_edge  <= (ref_cnt_r % 4'h3) == 4'h0;
    end
  end
endmodule

// ==== dv/gpio_and_clock_generation_test.sv ====
// self-checking bench for the multi-function pin and clock block
// assumes clock_source_model supplies the source edges; slow unit is 4
`timescale 1ns/1ps
module gpio_and_clock_generation_test;
  import gpio_clk_pkg::*;
  localparam logic [6:0] ADR [8] = '{ADDR_POWER_MGMT_ONE,
    ADDR_CLOCK_CONTROL, ADDR_SAMPLE_SLOW, ADDR_PIN_CONTROL,
    ADDR_PLL_INTEGER, ADDR_PLL_FRAC_HIGH, ADDR_PLL_FRAC_MID,
    ADDR_PLL_FRAC_LOW};
  localparam logic [8:0] RSV [8] = '{RST_POWER_MGMT_ONE,
    RST_CLOCK_CONTROL, RST_SAMPLE_SLOW, RST_PIN_CONTROL,
    RST_PLL_INTEGER, RST_PLL_FRAC_HIGH, RST_PLL_FRAC_MID,
    RST_PLL_FRAC_LOW};
  localparam int         FAC [6] = '{12, 8, 6, 4, 3, 2};
  localparam logic       FEX [8] = '{0, 0, 0, 1, 0, 0, 1, 0};
  logic        clk, rst, reg_wr, reg_rd, two_wire, spk_p, spk_n, mono;
  logic        thermal_sense_enable, fs_pulse, over_temp, mute, locked, jack, slow;
  logic [6:0]  reg_addr;
  logic [8:0]  reg_wdata, reg_rdata, d;
  logic        mclk_e, pll_e, pin_in, pin_out, pin_oe, sel_n;
  logic        o_spk_p, o_spk_n, o_mono, slow_tick, internal_master_clock_tick;
  logic        fs, fs_oe, bclk, bclk_oe, pll_pre;
  logic [3:0]  pll_int;
  logic [23:0] pll_frac;
  int          error_cnt, total_checks, cyc, n, s, p;

  // jack switch holds the pin whenever the block is not driving it
  assign pin_in = pin_oe ? pin_out : jack;

  clock_source_model src (.i_clk(clk), .i_rst(rst), .i_slow(slow),
    .o_mclk_edge(mclk_e), .o_pll_edge(pll_e));

  gpio_and_clock_generation #(.SLOW_UNIT(4)) DUT (.i_clk(clk),
    .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_two_wire_mode(two_wire),
    .i_speaker_pos_enable(spk_p), .i_speaker_neg_enable(spk_n),
    .i_mono_out_enable(mono), .i_thermal_sense_enable(thermal_sense_enable),
    .i_fs_pulse_format(fs_pulse), .i_over_temp(over_temp),
    .i_analog_mute_active(mute), .i_pll_locked(locked),
    .i_mclk_edge(mclk_e), .i_pll_edge(pll_e),
    .i_chip_select_pin(pin_in), .o_chip_select_pin(pin_out),
    .o_chip_select_pin_oe(pin_oe), .o_spi_select_n(sel_n),
    .o_speaker_pos_enable(o_spk_p), .o_speaker_neg_enable(o_spk_n),
    .o_mono_out_enable(o_mono), .o_slow_tick(slow_tick),
    .o_internal_master_clock_tick(internal_master_clock_tick), .o_frame_sync(fs),
    .o_frame_sync_oe(fs_oe), .o_bit_clock(bclk),
    .o_bit_clock_oe(bclk_oe), .o_pll_integer_part(pll_int),
    .o_pll_fraction_part(pll_frac), .o_pll_input_prescale(pll_pre));

  task automatic report_and_stop;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [8:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [6:0] a, output logic [8:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return internal_master_clock_tick;
      1: return slow_tick;
      2: return fs;
      3: return bclk;
      4: return pin_out;
      5: return pll_e;
      default: return 1'b1;
    endcase
  endfunction

  // events of c over one rise-to-rise period of s, bounded wait
  task automatic gap(input int s, input int c, output int cnt);
    int t;
    t = 0;
    cnt = 0;
    // skip one whole period: the first rise after a change can be partial
    repeat (2) begin
      while (pick(s) === 1'b1 && t < 4000) begin
        @(negedge clk);
        t++;
      end
      while (pick(s) !== 1'b1 && t < 4000) begin
        @(negedge clk);
        t++;
      end
    end
    for (int h = 0; h < 2; h++) begin
      while (pick(s) === (h == 0) && t < 4000) begin
        @(negedge clk);
        t++;
        cnt += int'(pick(c) === 1'b1);
      end
    end
    if (t >= 4000)
      error_cnt++;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the roughly ten thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    {reg_wr, reg_rd, two_wire, thermal_sense_enable, fs_pulse, over_temp, mute} = '0;
    {locked, jack, slow, reg_addr, reg_wdata} = '0;
    {spk_p, spk_n, mono, rst} = 4'hf;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(0);
    check(pll_int, 4'h8);
    check(pll_frac, 24'h3126e9);
    for (int i = 0; i < 8; i++) begin
      reg_read(ADR[i], d);
      check(d, RSV[i]);
    end
    reg_read(7'h10, d);
    check(d, 9'h000);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += int'(slow_tick === 1'b1);
    end
    check(n, 0);
    reg_write(ADDR_PLL_INTEGER, 9'h1ff);
    reg_read(ADDR_PLL_INTEGER, d);
    check(d, 9'h01f);
    check({pll_pre, pll_int}, 5'h1f);
    // pin functions, both polarities, in 2-wire mode
    @(posedge clk);
    {two_wire, thermal_sense_enable, over_temp, mute, locked} <= 5'h1f;
    for (s = 2; s < 8; s++) begin
      for (p = 0; p < 2; p++) begin
        if (s != 4) begin
          reg_write(ADDR_PIN_CONTROL, {5'h0, p[0], s[2:0]});
          settle(3);
          check(pin_out, FEX[s] ^ p[0]);
          check({pin_oe, sel_n}, 2'h3);
        end
      end
    end
    reg_write(ADDR_PIN_CONTROL, 9'h002);
    over_temp <= 1'b0;
    settle(3);
    check(pin_out, 1'b1);
    @(posedge clk);
    two_wire <= 1'b0;
    reg_write(ADDR_PIN_CONTROL, 9'h000);
    for (p = 0; p < 2; p++) begin
      @(posedge clk);
      jack <= p[0];
      settle(3);
      check({pin_oe, sel_n}, {1'b0, p[0]});
    end
    @(posedge clk);
    two_wire <= 1'b1;
    reg_write(ADDR_POWER_MGMT_ONE, 9'h020);
    for (p = 0; p < 4; p++) begin
      reg_write(ADDR_PIN_CONTROL, {3'h0, p[1:0], 4'h4});
      gap(4, 5, n);
      check(n, 2 * (p + 1));
    end
    // internal master clock from pin and pll, fast and slow source
    reg_write(ADDR_CLOCK_CONTROL, 9'h000);
    gap(0, 6, n);
    check(n, 4);
    reg_write(ADDR_CLOCK_CONTROL, 9'h040);
    gap(0, 6, n);
    check(n, 12);
    @(posedge clk);
    slow <= 1'b1;
    gap(0, 6, n);
    check(n, 24);
    @(posedge clk);
    slow <= 1'b0;
    reg_write(ADDR_CLOCK_CONTROL, 9'h100);
    gap(0, 6, n);
    check(n, 6);
    check({fs_oe, bclk_oe, fs}, 3'h0);
    reg_write(ADDR_CLOCK_CONTROL, 9'h009);
    settle(2);
    check({fs_oe, bclk_oe}, 2'h3);
    gap(2, 0, n);
    check(n, INTERNAL_MASTER_CLOCK_PER_FS);
    gap(3, 0, n);
    check(n, 8);
    @(posedge clk);
    fs_pulse <= 1'b1;
    gap(2, 0, n);
    check(n, INTERNAL_MASTER_CLOCK_PER_FS);
    for (s = 0; s < 6; s++) begin
      reg_write(ADDR_SAMPLE_SLOW, {5'h0, s[2:0], 1'b1});
      gap(1, 0, n);
      check(n, 4 * FAC[s]);
    end
    // jack detect: steering, hold-off, glitch and polarity
    reg_write(ADDR_SAMPLE_SLOW, 9'h001);
    reg_write(ADDR_PIN_CONTROL, 9'h001);
    jack <= 1'b0;
    settle(600);
    check({o_spk_p, o_spk_n, o_mono}, 3'h6);
    @(posedge clk);
    jack <= 1'b1;
    settle(20);
    check(o_mono, 1'b0);
    settle(600);
    check({o_spk_p, o_spk_n, o_mono}, 3'h1);
    @(posedge clk);
    jack <= 1'b0;
    @(posedge clk);
    jack <= 1'b1;
    settle(600);
    check(o_mono, 1'b1);
    reg_write(ADDR_PIN_CONTROL, 9'h009);
    settle(600);
    check({o_spk_p, o_spk_n, o_mono}, 3'h6);
    report_and_stop();
  end
endmodule
